//--- verilog/swd_watchdog.sv
// watchdog timer with reset sequencer of a processor supervisor
`timescale 1ns/1ps
module swd_watchdog #(
  parameter logic [31:0] TIMEOUT_CYC = swd_pkg::TIMEOUT_CYC,
  parameter logic [31:0] EXT_TIMEOUT_CYC = swd_pkg::EXT_TIMEOUT_CYC,
  parameter logic [31:0] PULSE_CYC = swd_pkg::PULSE_CYC,
  parameter logic [31:0] RST_HOLD_CYC = swd_pkg::RST_HOLD_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic activity_in,
  input wire logic supply_low_in,
  input wire logic manual_reset_n_in,
  input wire logic timeout_select_in,
  output logic fault_level_n_out,
  output logic fault_pulse_n_out,
  output logic reset_n_out,
  output logic reset_out
);
  logic act_s1_r;
  logic act_s2_r;
  logic act_s3_r;
  swd_pkg::swd_rst_e state_r;
  swd_pkg::swd_rst_e state_nxt;
  logic dly_act_r;
  logic [31:0] wd_cnt;
  logic [31:0] pulse_cnt;
  logic [31:0] dly_cnt;
  logic [31:0] hold_cnt;

  // synchroniser and edge
  // stage one feeds stage two only; edges compare stages two and three
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      act_s1_r <= 1'b0;
      act_s2_r <= 1'b0;
      act_s3_r <= 1'b0;
    end else begin
      act_s1_r <= activity_in;
      act_s2_r <= act_s1_r;
      act_s3_r <= act_s2_r;
    end
  end
  wire act_edge = act_s2_r ^ act_s3_r;

  // system reset request and stretch
  wire rst_req = supply_low_in | ~manual_reset_n_in;
  wire sys_rst = (state_r != swd_pkg::SR_RUN);
  wire hold_done = (hold_cnt == RST_HOLD_CYC - 32'd1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      swd_pkg::SR_ASSERT: begin
        if (!rst_req) state_nxt = swd_pkg::SR_HOLD;
      end
      swd_pkg::SR_HOLD: begin
        if (rst_req) state_nxt = swd_pkg::SR_ASSERT;
        else if (hold_done) state_nxt = swd_pkg::SR_RUN;
      end
      swd_pkg::SR_RUN: begin
        if (rst_req) state_nxt = swd_pkg::SR_ASSERT;
      end
      default: state_nxt = swd_pkg::SR_ASSERT;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= swd_pkg::SR_ASSERT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // capacitor period is a parameter, since the slope is analog
  wire [31:0] period_w = timeout_select_in ? TIMEOUT_CYC : EXT_TIMEOUT_CYC;

  // timeout detect
  // >= guards against a period change skipping the terminal count
  wire wd_done = ~sys_rst & ~act_edge & (wd_cnt >= period_w - 32'd1);
  wire pulse_act = ~fault_pulse_n_out;
  wire pulse_done = pulse_act & (pulse_cnt == PULSE_CYC - 32'd1);
  wire dly_done = dly_act_r & (dly_cnt == swd_pkg::LEVEL_DLY_CYC - 32'd1);

  // count restarts after each timeout for repeated pulses
  swd_counter #(.WIDTH(swd_pkg::CNT_W)) u_wd_cnt (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clr_in(sys_rst | act_edge | wd_done),
    .cnt_out(wd_cnt)
  );

  swd_counter #(.WIDTH(swd_pkg::CNT_W)) u_pulse_cnt (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clr_in(~pulse_act),
    .cnt_out(pulse_cnt)
  );

  swd_counter #(.WIDTH(swd_pkg::CNT_W)) u_dly_cnt (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clr_in(~dly_act_r),
    .cnt_out(dly_cnt)
  );

  swd_counter #(.WIDTH(swd_pkg::CNT_W)) u_hold_cnt (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clr_in(state_r != swd_pkg::SR_HOLD),
    .cnt_out(hold_cnt)
  );

  // pulse output, low for the pulse width
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_pulse_n_out <= swd_pkg::FAULT_N_RST;
    end else if (sys_rst || pulse_done) begin
      fault_pulse_n_out <= 1'b1;
    end else if (wd_done) begin
      fault_pulse_n_out <= 1'b0;
    end
  end

  // level delay after pulse fall
  // an edge during the delay cancels the pending fault
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dly_act_r <= 1'b0;
    end else if (sys_rst || act_edge || dly_done) begin
      dly_act_r <= 1'b0;
    end else if (wd_done) begin
      dly_act_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_level_n_out <= swd_pkg::FAULT_N_RST;
    end else if (sys_rst || act_edge) begin
      fault_level_n_out <= 1'b1;
    end else if (dly_done) begin
      fault_level_n_out <= 1'b0;
    end
  end

  // complementary reset outputs
  // both loaded from the same state so they never disagree
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reset_n_out <= swd_pkg::RESET_N_RST;
      reset_out <= ~swd_pkg::RESET_N_RST;
    end else begin
      reset_n_out <= ~sys_rst;
      reset_out <= sys_rst;
    end
  end

  // checks on the watchdog behaviour
  rst_invert_a: assert property (
    @(posedge mclk_in) disable iff (rst_in) reset_out == ~reset_n_out)
    else $error("reset outputs not complementary");

  rst_faults_high_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    sys_rst |=> fault_level_n_out && fault_pulse_n_out && wd_cnt == 32'd0)
    else $error("faults or count not cleared in reset");

  // one cycle to enter the sequencer and one for the output flops, so a
  // supply drop is judged from its third cycle on
  supply_low_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    supply_low_in ##1 supply_low_in |=> fault_level_n_out && !reset_n_out)
    else $error("level fault low or reset off during low supply");

  edge_restart_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    act_edge |=> wd_cnt == 32'd0 && fault_level_n_out)
    else $error("activity edge did not restart watchdog");

  timeout_pulse_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    $fell(fault_pulse_n_out) |-> $past(wd_cnt) >= $past(period_w) - 32'd1)
    else $error("pulse fault fell before the timeout");

  pulse_width_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    $rose(fault_pulse_n_out) && !$past(sys_rst) |-> $past(pulse_cnt) == PULSE_CYC - 32'd1)
    else $error("pulse fault width wrong");

  level_delay_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    $fell(fault_level_n_out) |-> !$past(fault_pulse_n_out, 14) && $past(fault_pulse_n_out, 15))
    else $error("level fault not 70 ns after pulse fall");

  level_stays_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !fault_level_n_out && !act_edge && !sys_rst |=> !fault_level_n_out)
    else $error("level fault released without activity");

  hold_time_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    $fell(reset_out) |-> $past(hold_cnt, 2) == RST_HOLD_CYC - 32'd1)
    else $error("reset stretch length wrong");
endmodule : swd_watchdog

//--- verilog/swd_pkg.sv
// shared constants for the supervisor watchdog timer
package swd_pkg;
  // clock rate
  localparam logic [31:0] CLK_MHZ = 32'd200;
  localparam logic [31:0] CLK_PERIOD_NS = 32'd5;
  // counter width
  localparam int CNT_W = 32;
  // internal fixed watchdog timeout, milliseconds
  localparam logic [31:0] TIMEOUT_MS = 32'd1600;
  localparam logic [31:0] TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 32'd1000;
  // capacitor timeout slope, microseconds per nanofarad
  localparam logic [31:0] K_3V_US_PER_NF = 32'd27000;
  localparam logic [31:0] K_5V_US_PER_NF = 32'd16200;
  // default capacitor on the select input, nanofarads
  localparam logic [31:0] CAP_NF = 32'd100;
  localparam logic [31:0] EXT_TIMEOUT_CYC = K_5V_US_PER_NF * CAP_NF * CLK_MHZ;
  // fault pulse width, microseconds
  localparam logic [31:0] PULSE_US = 32'd1700;
  localparam logic [31:0] PULSE_CYC = PULSE_US * CLK_MHZ;
  // pulse-to-level delay, nanoseconds (least time, rounded up)
  localparam logic [31:0] LEVEL_DLY_NS = 32'd70;
  localparam logic [31:0] LEVEL_DLY_CYC =
    (LEVEL_DLY_NS + CLK_PERIOD_NS - 32'd1) / CLK_PERIOD_NS;
  // reset stretch after release, milliseconds
  localparam logic [31:0] RST_HOLD_MS = 32'd200;
  localparam logic [31:0] RST_HOLD_CYC = RST_HOLD_MS * CLK_MHZ * 32'd1000;
  // reset values of the outputs
  localparam logic FAULT_N_RST = 1'b1;
  localparam logic RESET_N_RST = 1'b0;
  // system reset sequencer states
  typedef enum logic [1:0] {
    SR_ASSERT,
    SR_HOLD,
    SR_RUN
  } swd_rst_e;
endpackage : swd_pkg

//--- verilog/swd_counter.sv
// up counter with synchronous clear, used for every interval
`timescale 1ns/1ps
module swd_counter #(
  parameter int WIDTH = 32
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  output logic [WIDTH-1:0] cnt_out
);
  // counts every cycle unless cleared; wraps only if nobody clears it
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_out <= '0;
    end else if (clr_in) begin
      cnt_out <= '0;
    end else begin
      cnt_out <= cnt_out + 1'b1;
    end
  end
endmodule : swd_counter

//--- verification/swd_host_model.sv
// host processor model that kicks the watchdog activity line
`timescale 1ns/1ps
module swd_host_model #(
  parameter int GAP = 50
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic kick_en_in,
  input wire logic mr_n_in,
  input wire logic fb_en_in,
  input wire logic latch_en_in,
  input wire logic fault_level_n_in,
  input wire logic fault_pulse_n_in,
  output logic activity_out,
  output logic manual_reset_n_out
);
  logic [15:0] gap_r;
  logic pulse_prev_r;
  logic latch_q_r;

  // outside shutdown flip-flop
  // samples the level fault as the pulse fault falls; the level lags the pulse,
  // so a first fault still reads high and only a second one in a row latches
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_prev_r <= 1'b1;
      latch_q_r <= 1'b1;
    end else begin
      pulse_prev_r <= fault_pulse_n_in;
      if (!latch_en_in) begin
        latch_q_r <= 1'b1;
      end else if (pulse_prev_r && !fault_pulse_n_in) begin
        latch_q_r <= fault_level_n_in;
      end
    end
  end

  // level fault wire-ORed into manual reset when enabled
  assign manual_reset_n_out = mr_n_in & latch_q_r & (fault_level_n_in | ~fb_en_in);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r <= 16'h0000;
      activity_out <= 1'b0;
    end else if (kick_en_in && gap_r >= 16'(GAP - 1)) begin
      gap_r <= 16'h0000;
      activity_out <= ~activity_out;
    end else begin
      gap_r <= kick_en_in ? gap_r + 16'h0001 : 16'h0000;
    end
  end
endmodule : swd_host_model

//--- verification/tb_swd_watchdog.sv
// self-checking bench for the supervisor watchdog timer
`timescale 1ns/1ps
module tb_swd_watchdog;
  // shortened counts so the run stays small
  localparam logic [31:0] TO = 32'h000000C8;
  localparam logic [31:0] EXT = 32'h0000012C;
  localparam logic [31:0] PW = 32'h00000028;
  localparam logic [31:0] HOLD = 32'h00000014;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic kick_en = 1'b1;
  logic supply_low = 1'b0;
  logic mr_n = 1'b1;
  logic sel = 1'b1;
  logic fb_en = 1'b0;
  logic latch_en = 1'b0;
  logic act, lvl_n, pls_n, rst_n, rst_hi, mr_in;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int low_cnt = 0;
  int n, n1, n2;
  swd_host_model #(.GAP(50)) u_swd_host_model (.mclk_in(mclk_in), .rst_in(rst_in),
    .kick_en_in(kick_en), .mr_n_in(mr_n), .fb_en_in(fb_en), .latch_en_in(latch_en),
    .fault_level_n_in(lvl_n), .fault_pulse_n_in(pls_n), .activity_out(act),
    .manual_reset_n_out(mr_in));
  swd_watchdog #(.TIMEOUT_CYC(TO), .EXT_TIMEOUT_CYC(EXT), .PULSE_CYC(PW),
    .RST_HOLD_CYC(HOLD)) u_swd_watchdog (.mclk_in(mclk_in), .rst_in(rst_in),
    .activity_in(act), .supply_low_in(supply_low), .manual_reset_n_in(mr_in),
    .timeout_select_in(sel), .fault_level_n_out(lvl_n), .fault_pulse_n_out(pls_n),
    .reset_n_out(rst_n), .reset_out(rst_hi));
  // 200 MHz clock
  initial forever #2.5 mclk_in = ~mclk_in;
  // pulse-low tally and hang guard, ceiling well above the ~3750 cycles used
  always @(posedge mclk_in) begin
    cyc++;
    if (pls_n === 1'b0) low_cnt++;
    if (cyc == 8000) begin
      fails++;
      summarize();
    end
  end
  function automatic logic val(input int w);
    case (w)
      0: return pls_n;
      1: return lvl_n;
      2: return rst_n;
      default: return act;
    endcase
  endfunction : val
  task automatic wait_for(input int w, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (val(w) !== v && cnt < lim) begin
      @(posedge mclk_in);
      #1;
      cnt++;
    end
  endtask : wait_for
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check
  task automatic check_rng(input string nm, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : check_rng
  task automatic s_power_up();
    repeat (20) @(posedge mclk_in);
    #1;
    check("fault_level_n_out", 1, lvl_n);
    check("fault_pulse_n_out", 1, pls_n);
    check("reset_out", 1, rst_hi);
    @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    wait_for(2, 1'b1, 40, n);
    check_rng("reset hold", HOLD, HOLD + 4, n);
    check("reset_out", 0, rst_hi);
  endtask : s_power_up
  task automatic s_kick();
    int base;
    base = low_cnt;
    repeat (3 * TO) @(posedge mclk_in);
    #1;
    check("pulse low cycles", 0, low_cnt - base);
    check("fault_level_n_out", 1, lvl_n);
  endtask : s_kick
  // last toggle, then silence: time the pulse, the level and the repeat
  task automatic s_timeout(input logic s, input int period);
    @(posedge mclk_in);
    kick_en <= 1'b1;
    sel <= s;
    #1;
    wait_for(3, ~act, 60, n);
    @(posedge mclk_in);
    kick_en <= 1'b0;
    #1;
    wait_for(0, 1'b0, period + 40, n);
    check_rng("timeout", period - 5, period + 10, n);
    wait_for(1, 1'b0, 30, n1);
    check("level delay", swd_pkg::LEVEL_DLY_CYC, n1);
    wait_for(0, 1'b1, PW + 10, n2);
    check("pulse width", PW, n1 + n2);
    wait_for(0, 1'b0, period + 10, n);
    check("repeat period", period, n1 + n2 + n);
    check("fault_level_n_out", 0, lvl_n);
  endtask : s_timeout
  task automatic s_recover();
    @(posedge mclk_in);
    kick_en <= 1'b1;
    #1;
    wait_for(3, ~act, 60, n);
    @(posedge mclk_in);
    kick_en <= 1'b0;
    #1;
    wait_for(1, 1'b1, 8, n);
    check_rng("level recovery", 1, 5, n);
  endtask : s_recover
  // src 0 is a supply drop, src 1 a manual reset
  task automatic s_sysreset(input logic src);
    @(posedge mclk_in);
    if (src) mr_n <= 1'b0;
    else supply_low <= 1'b1;
    #1;
    wait_for(2, 1'b0, 5, n);
    check("reset_out", 1, rst_hi);
    check("fault_level_n_out", 1, lvl_n);
    check("fault_pulse_n_out", 1, pls_n);
    repeat (TO + 10) @(posedge mclk_in);
    #1;
    check("fault_level_n_out", 1, lvl_n);
    check("reset_n_out", 0, rst_n);
    @(posedge mclk_in);
    mr_n <= 1'b1;
    supply_low <= 1'b0;
    #1;
    wait_for(2, 1'b1, 40, n);
    check_rng("reset hold", HOLD, HOLD + 4, n);
    check("reset_out", 0, rst_hi);
  endtask : s_sysreset
  // level fault fed back into manual reset: a stretched reset per timeout,
  // spaced by a timeout plus the stretch plus the level delay and a few cycles of latency
  task automatic s_feedback();
    @(posedge mclk_in);
    sel <= 1'b1;
    fb_en <= 1'b1;
    #1;
    wait_for(2, 1'b0, TO + 60, n);
    check("reset_n_out", 0, rst_n);
    wait_for(2, 1'b1, HOLD + 10, n1);
    check_rng("feedback reset width", HOLD, HOLD + 4, n1);
    wait_for(2, 1'b0, TO + HOLD + 40, n2);
    check_rng("feedback reset spacing", TO + HOLD, TO + HOLD + 20, n1 + n2);
    @(posedge mclk_in);
    fb_en <= 1'b0;
    #1;
    wait_for(2, 1'b1, HOLD + 10, n);
    check("reset_n_out", 1, rst_n);
  endtask : s_feedback
  // outside flip-flop: two faults in a row latch reset,
  // an activity toggle between them keeps the system running
  task automatic s_latch(input logic kick_mid);
    @(posedge mclk_in);
    latch_en <= 1'b1;
    #1;
    wait_for(0, 1'b0, TO + 40, n);
    if (kick_mid) begin
      @(posedge mclk_in);
      kick_en <= 1'b1;
      #1;
      wait_for(3, ~act, 60, n1);
      @(posedge mclk_in);
      kick_en <= 1'b0;
      #1;
    end
    wait_for(2, 1'b0, TO + 80, n);
    check("reset_n_out", kick_mid, rst_n);
    if (!kick_mid) check_rng("latch delay", TO, TO + 10, n);
    repeat (HOLD + 10) @(posedge mclk_in);
    #1;
    check("reset_n_out", kick_mid, rst_n);
    @(posedge mclk_in);
    latch_en <= 1'b0;
    #1;
    wait_for(2, 1'b1, HOLD + 40, n);
    check("reset_n_out", 1, rst_n);
  endtask : s_latch
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    s_power_up();
    s_kick();
    s_timeout(1'b1, TO);
    s_recover();
    s_timeout(1'b0, EXT);
    s_sysreset(1'b0);
    s_sysreset(1'b1);
    s_feedback();
    s_latch(1'b0);
    s_latch(1'b1);
    summarize();
  end
endmodule : tb_swd_watchdog
